// ---- hicl_defs.svh ----
`ifndef HICL_DEFS_SVH
`define HICL_DEFS_SVH

// Number of configuration bytes and where they start in the EEPROM.
`define HICL_CFG_BYTES      3'h5
`define HICL_CFG_LAST_IDX   3'h4
`define HICL_CFG_BASE       8'h00

// Byte addresses of the five configuration bytes.
`define HICL_ADDR_ROLLER    3'h0
`define HICL_ADDR_BTN_MASK  3'h1
`define HICL_ADDR_EXT_MASK  3'h2
`define HICL_ADDR_APP       3'h3
`define HICL_ADDR_RESUME    3'h4

// Field positions inside the roller pin configuration byte.
`define HICL_ROLLER_CNT     1:0
`define HICL_PIN_DIR        3:2
`define HICL_ROLLER_SINK    7:4

// Field positions inside the extended report mask.
`define HICL_EXT_ENABLE     5:0
`define HICL_EXT_IO         7:6

// Field positions inside the application configuration byte.
`define HICL_FUNC_SEL       1:0
`define HICL_DEBOUNCE_SEL   3:2
`define HICL_LED_SINK       7:4

// Field positions inside the remote resume configuration byte.
`define HICL_POLL_SEL       2:0
`define HICL_RESUME_EN      3
`define HICL_RESUME_RSVD    7:4

// Encodings.
`define HICL_FUNC_MOUSE     2'h0
`define HICL_FUNC_RSVD      2'h1
`define HICL_FUNC_JOY       2'h2
`define HICL_FUNC_PAD       2'h3
`define HICL_DIR_BOTH_OUT   2'h0
`define HICL_DIR_FIRST_OUT  2'h1
`define HICL_DIR_INVALID    2'h2
`define HICL_DIR_BOTH_IN    2'h3
`define HICL_POLL_RSVD      3'h7
`define HICL_ROLLERS_ONE    2'h1
`define HICL_ROLLERS_TWO    2'h2
`define HICL_ROLLERS_THREE  2'h3

// Pin masks in extended report order {horiz_in_b, horiz_in_a, vert_in_b, vert_in_a, aux_in_b, aux_in_a}.
`define HICL_PAIR_HORIZ     6'h30
`define HICL_PAIR_VERT      6'h0c
`define HICL_PAIR_AUX       6'h03

// Sink current code limits and endpoint packet size.
`define HICL_ROLLER_SINK_MAX 4'h9
`define HICL_LED_SINK_MAX    4'h8
`define HICL_MAX_PACKET      4'h8

// Timing: one step of debounce and poll intervals, and the clock rate.
`define HICL_STEP_MS        15
`define HICL_CLK_KHZ        200000
`define HICL_RESET_MIN_NS   10

`endif

// ---- hicl_pkg.sv ----
package hicl_pkg;

  // Configuration load sequence; the first item is the state left by reset.
  typedef enum logic [1:0] {
    LD_REQ,
    LD_WAIT,
    LD_OPER
  } hicl_load_t;

  // Pins from the outside world, all active low as buttons.
  typedef struct packed {
    logic       progModeN;
    logic [1:0] progPinN;
    logic [5:0] rollerPinN;
    logic [7:0] buttonPinN;
  } hicl_pins_t;

  // Whole state of the loader in one record.
  typedef struct packed {
    hicl_load_t  ld;
    logic [2:0]  byteIdx;
    logic        ready;
    logic        eeRdReq;
    logic [7:0]  eeRdAddr;
    logic [7:0]  cfgRoller;
    logic [7:0]  cfgBtnMask;
    logic [7:0]  cfgExtMask;
    logic [7:0]  cfgApp;
    logic [7:0]  cfgResume;
    logic [16:0] sync1;
    logic [16:0] sync2;
    logic [31:0] stepCnt;
    logic        stepTick;
    logic [1:0]  debCnt;
    logic [15:0] sample;
    logic [15:0] deb;
    logic [15:0] report;
    logic [2:0]  pollCnt;
    logic [5:0]  motionSnap;
    logic        pollWake;
    logic        remoteWake;
    logic [1:0]  progVal;
    logic [1:0]  progOut;
    logic [1:0]  progOe;
    logic        ledOe;
    logic        serCs;
    logic        serSk;
    logic        serDi;
    logic [3:0]  rollerSink;
    logic [3:0]  ledSink;
    logic        cfgError;
    logic [3:0]  epMax;
  } hicl_state_t;

endpackage

// ---- hid_input_config_loader.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hicl_defs.svh"

module hid_input_config_loader #(
  // Clock cycles in one 15 ms step at the system clock rate.
  parameter int unsigned STEP_CYCLES = (`HICL_STEP_MS * `HICL_CLK_KHZ)
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Raw pins from outside the clock domain.
  input  wire hicl_pkg::hicl_pins_t pinsIn,
  // Internal EEPROM read port.
  output logic                   eeRdReq,
  output logic [7:0]             eeRdAddr,
  input  wire logic [7:0]        eeRdData,
  input  wire logic              eeRdValid,
  // Internal EEPROM serial port used in programming mode.
  output logic                   eeSerCs,
  output logic                   eeSerSk,
  output logic                   eeSerDi,
  input  wire logic              eeSerDo,
  // USB core side.
  input  wire logic              usbBusReset,
  input  wire logic              usbSuspend,
  input  wire logic              setReportStrobe,
  input  wire logic [1:0]        setReportData,
  output logic [3:0]             ep0MaxPacket,
  output logic [3:0]             ep1MaxPacket,
  // Report data and wakeup events.
  output logic [15:0]            reportBits,
  output logic                   cfgReady,
  output logic                   cfgError,
  output logic                   pollWake,
  output logic                   remoteWakeReq,
  // Programmable pins and LED pin, open-collector except the first programmable pin in programming mode.
  output logic [1:0]             progPinOut,
  output logic [1:0]             progPinOe,
  output logic                   ledPinOut,
  output logic                   ledPinOe,
  // Analog trims for the pad drivers.
  output logic [3:0]             rollerSinkCode,
  output logic [3:0]             ledSinkCode
);

  // Every interval here is a whole number of 15 ms steps.
  // One long step counter serves all timers, so the debounce
  // and poll counters need only a few bits each.
  // A short STEP_CYCLES in simulation shrinks all intervals alike.
  // The reset pin width is the driver's duty; nothing here times it.
  // Pins reach the logic one to two cycles after they move.

  // Motion pins belong to the roller counters or the pot timer,
  // so they never appear as buttons in a report.
  // Pairs are used in a fixed order, so a count picks them.
  // Pins used by a roller or potentiometer, in extended report order.
  function automatic logic [5:0] motion_pins(input logic [1:0] func, input logic [1:0] cnt);
    logic [5:0] m;
    m = 6'h00;
    if (func == `HICL_FUNC_JOY) begin
      m = `HICL_PAIR_HORIZ;
    end else if (func == `HICL_FUNC_MOUSE) begin
      if (cnt >= `HICL_ROLLERS_ONE) begin
        m = m | `HICL_PAIR_HORIZ;
      end
      if (cnt >= `HICL_ROLLERS_TWO) begin
        m = m | `HICL_PAIR_VERT;
      end
      if (cnt == `HICL_ROLLERS_THREE) begin
        m = m | `HICL_PAIR_AUX;
      end
    end
    return m;
  endfunction

  // Which of the two programmable pins act as inputs; bit 1 is the second pin.
  // An invalid direction code is also raised on cfgError.
  function automatic logic [1:0] prog_inputs(input logic [1:0] dir);
    logic [1:0] m;
    m = 2'h3;
    case (dir)
      `HICL_DIR_BOTH_OUT:  m = 2'h0;
      `HICL_DIR_FIRST_OUT: m = 2'h2;
      `HICL_DIR_BOTH_IN:   m = 2'h3;
      default:             m = 2'h3; // Invalid code parks both pins as inputs, the safe side.
    endcase
    return m;
  endfunction

  // All state lives in one record; the comb process builds the
  // next copy and the clocked process registers it.
  // Outputs therefore come straight from flip-flops.
  hicl_pkg::hicl_state_t st_r;       // Registered state.
  hicl_pkg::hicl_state_t st_nxt;     // Next state.

  logic [1:0]  funcSel;              // Function select field.
  logic [1:0]  rollerCnt;            // Roller pair count field.
  logic [1:0]  pinDir;               // Programmable pin direction field.
  logic [1:0]  debSel;               // Debounce select field.
  logic [2:0]  pollSel;              // Wakeup poll interval field.
  logic        resumeEn;             // Remote resume enable bit.
  logic [5:0]  motionMask;           // Pins owned by rollers or pots.
  logic [1:0]  progInMask;           // Programmable pins used as inputs.
  logic [15:0] pressed;              // Debounced inputs, active high.
  logic [5:0]  motionNow;            // Current level of motion pins.
  logic [7:0]  maskPlusOne;          // Helper for the contiguity check.
  logic        progMode;             // Programming mode, synchronised.

  // Next-state logic for the whole block.
  always_comb begin
    st_nxt      = st_r;
    funcSel     = st_r.cfgApp[`HICL_FUNC_SEL];
    rollerCnt   = st_r.cfgRoller[`HICL_ROLLER_CNT];
    pinDir      = st_r.cfgRoller[`HICL_PIN_DIR];
    debSel      = st_r.cfgApp[`HICL_DEBOUNCE_SEL];
    pollSel     = st_r.cfgResume[`HICL_POLL_SEL];
    resumeEn    = st_r.cfgResume[`HICL_RESUME_EN];
    motionMask  = motion_pins(funcSel, rollerCnt);
    progInMask  = prog_inputs(pinDir);
    pressed     = st_r.deb;
    motionNow   = st_r.sync2[13:8] & motionMask;
    maskPlusOne = st_r.cfgBtnMask + 8'h01;
    progMode    = ~st_r.sync2[16];

    // Two-stage synchroniser for every pin; only sync2 feeds logic.
    st_nxt.sync1 = pinsIn;
    st_nxt.sync2 = st_r.sync1;

    // Pulses default low each cycle.
    st_nxt.eeRdReq    = 1'b0;
    st_nxt.stepTick   = 1'b0;
    st_nxt.pollWake   = 1'b0;
    st_nxt.remoteWake = 1'b0;

    // Configuration load: one EEPROM read per byte, five in total.
    // Data is taken only with its valid strobe, one request at a time.
    // The bus may carry anything between answers.
    case (st_r.ld)
      hicl_pkg::LD_REQ: begin
        st_nxt.eeRdReq  = 1'b1;
        st_nxt.eeRdAddr = `HICL_CFG_BASE + {5'h00, st_r.byteIdx};
        st_nxt.ld       = hicl_pkg::LD_WAIT;
      end
      hicl_pkg::LD_WAIT: begin
        if (eeRdValid) begin
          case (st_r.byteIdx)
            `HICL_ADDR_ROLLER:   st_nxt.cfgRoller  = eeRdData;
            `HICL_ADDR_BTN_MASK: st_nxt.cfgBtnMask = eeRdData;
            `HICL_ADDR_EXT_MASK: st_nxt.cfgExtMask = eeRdData;
            `HICL_ADDR_APP:      st_nxt.cfgApp     = eeRdData;
            default:             st_nxt.cfgResume  = eeRdData;
          endcase
          if (st_r.byteIdx == `HICL_CFG_LAST_IDX) begin
            st_nxt.ld    = hicl_pkg::LD_OPER;
            st_nxt.ready = 1'b1;
          end else begin
            st_nxt.byteIdx = st_r.byteIdx + 3'h1;
            st_nxt.ld      = hicl_pkg::LD_REQ;
          end
        end
      end
      hicl_pkg::LD_OPER: begin
        st_nxt.ld = hicl_pkg::LD_OPER; // Operational until the next reset.
      end
      default: begin
        st_nxt.ld = hicl_pkg::LD_REQ;
      end
    endcase

    // A bus reset restarts the load from the first byte, wherever it was.
    if (usbBusReset) begin
      // A request due on this edge would carry the old index,
      // so it is dropped and reissued from the first byte.
      st_nxt.eeRdReq = 1'b0;
      st_nxt.ld      = hicl_pkg::LD_REQ;
      st_nxt.byteIdx = 3'h0;
      st_nxt.ready   = 1'b0;
    end

    // Free-running 15 ms step shared by debounce and poll timers.
    // It runs whether loaded or not, so the first interval after
    // a load may be short by up to one step.
    if (st_r.stepCnt == 32'(STEP_CYCLES - 1)) begin
      st_nxt.stepCnt  = 32'h0000_0000;
      st_nxt.stepTick = 1'b1;
    end else begin
      st_nxt.stepCnt = st_r.stepCnt + 32'h0000_0001;
    end

    // Debounce: sample every (code+1) steps and accept a level seen twice running.
    // This costs one extra interval of latency but needs no per-pin counters.
    // A bounce shorter than one interval is never seen twice.
    if (st_r.stepTick) begin
      if (st_r.debCnt == debSel) begin
        st_nxt.debCnt = 2'h0;
        st_nxt.sample = ~st_r.sync2[15:0];
        st_nxt.deb    = (~st_r.sync2[15:0] & ~(~st_r.sync2[15:0] ^ st_r.sample))
                      | (st_r.deb & (~st_r.sync2[15:0] ^ st_r.sample));
      end else begin
        st_nxt.debCnt = st_r.debCnt + 2'h1;
      end
    end

    // Report bits: buttons, freed roller pins and input-configured output pins.
    // Reports stay zero in programming mode, where the first
    // button pins carry the serial port instead.
    if (st_r.ready && !progMode) begin
      st_nxt.report[7:0]   = pressed[7:0] & st_r.cfgBtnMask;
      st_nxt.report[13:8]  = pressed[13:8] & st_r.cfgExtMask[`HICL_EXT_ENABLE] & ~motionMask;
      st_nxt.report[15:14] = pressed[15:14] & st_r.cfgExtMask[`HICL_EXT_IO] & progInMask;
    end else begin
      st_nxt.report = 16'h0000;
    end

    // Configuration sanity: bad patterns are flagged but still applied.
    // A faulty byte then shows on the pins instead of being hidden.
    st_nxt.cfgError = st_r.ready &&
                      (((st_r.cfgBtnMask & maskPlusOne) != 8'h00) ||
                       (pinDir == `HICL_DIR_INVALID) ||
                       (funcSel == `HICL_FUNC_RSVD) ||
                       (pollSel == `HICL_POLL_RSVD) ||
                       (st_r.cfgResume[`HICL_RESUME_RSVD] != 4'h0));

    // Host set-report writes the values for the output pins.
    // Values sent before the load completes are dropped, since
    // the direction of the pins is not yet known.
    if (setReportStrobe && st_r.ready) begin
      st_nxt.progVal = setReportData;
    end

    // Open-collector outside programming mode: enable pulls low for a 0, release for a 1.
    if (progMode) begin
      // Serial port for the EEPROM: first three buttons in, first output pin carries data out.
      st_nxt.serCs      = ~st_r.sync2[0];
      st_nxt.serSk      = ~st_r.sync2[1];
      st_nxt.serDi      = ~st_r.sync2[2];
      st_nxt.progOut    = {1'b0, eeSerDo};
      st_nxt.progOe     = 2'h1;
    end else begin
      st_nxt.serCs   = 1'b0;
      st_nxt.serSk   = 1'b0;
      st_nxt.serDi   = 1'b0;
      st_nxt.progOut = 2'h0;
      st_nxt.progOe  = st_r.ready ? (~progInMask & ~st_r.progVal) : 2'h0;
    end

    // Button 8 pin turns the roller LEDs off while suspended when not a button.
    st_nxt.ledOe = st_r.ready && !st_r.cfgBtnMask[7] && usbSuspend;

    // Pad trims, clamped to the highest defined codes.
    // Clamping rather than wrapping means an oversized code
    // gives the largest current, never the smallest.
    st_nxt.rollerSink = (st_r.cfgRoller[`HICL_ROLLER_SINK] > `HICL_ROLLER_SINK_MAX) ?
                        `HICL_ROLLER_SINK_MAX : st_r.cfgRoller[`HICL_ROLLER_SINK];
    st_nxt.ledSink    = (st_r.cfgApp[`HICL_LED_SINK] > `HICL_LED_SINK_MAX) ?
                        `HICL_LED_SINK_MAX : st_r.cfgApp[`HICL_LED_SINK];

    // Suspend polling: wake briefly every (code+1) steps and compare motion pins.
    // The snapshot follows the pins while not polling, so only
    // movement during suspend can raise a wakeup.
    // Polls land only on a step tick, so each pulse is one cycle.
    // The reserved code keeps polling off altogether.
    if (st_r.ready && usbSuspend && resumeEn && (pollSel != `HICL_POLL_RSVD)) begin
      if (st_r.stepTick) begin
        if (st_r.pollCnt == pollSel) begin
          st_nxt.pollCnt    = 3'h0;
          st_nxt.pollWake   = 1'b1;
          st_nxt.remoteWake = (motionNow != st_r.motionSnap);
          st_nxt.motionSnap = motionNow;
        end else begin
          st_nxt.pollCnt = st_r.pollCnt + 3'h1;
        end
      end
    end else begin
      st_nxt.pollCnt    = 3'h0;
      st_nxt.motionSnap = motionNow; // Baseline is the level at suspend entry.
    end

    // Both endpoints carry at most eight bytes per packet.
    st_nxt.epMax = `HICL_MAX_PACKET;
  end

  // Single clocked process on the one system clock.
  // Synchronisers reset to ones, the released level of every pin,
  // so no false press follows reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r       <= '0;
      st_r.sync1 <= 17'h1ffff;
      st_r.sync2 <= 17'h1ffff;
      st_r.epMax <= `HICL_MAX_PACKET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state record.
  // The lamp pin only ever pulls low; its data bit stays zero.
  assign eeRdReq        = st_r.eeRdReq;
  assign eeRdAddr       = st_r.eeRdAddr;
  assign eeSerCs        = st_r.serCs;
  assign eeSerSk        = st_r.serSk;
  assign eeSerDi        = st_r.serDi;
  assign ep0MaxPacket   = st_r.epMax;
  assign ep1MaxPacket   = st_r.epMax;
  assign reportBits     = st_r.report;
  assign cfgReady       = st_r.ready;
  assign cfgError       = st_r.cfgError;
  assign pollWake       = st_r.pollWake;
  assign remoteWakeReq  = st_r.remoteWake;
  assign progPinOut     = st_r.progOut;
  assign progPinOe      = st_r.progOe;
  assign ledPinOut      = st_r.progOut[1];
  assign ledPinOe       = st_r.ledOe;
  assign rollerSinkCode = st_r.rollerSink;
  assign ledSinkCode    = st_r.ledSink;

endmodule
`default_nettype wire

// ---- hicl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the loader's ports for load order, report gating and suspend behaviour.
module hicl_checker #(
  parameter int unsigned STEP_CYCLES = 20  // Interval step in cycles, kept equal to the loader's.
) (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rst,
  // EEPROM read port.
  input wire logic        eeRdReq,
  input wire logic [7:0]  eeRdAddr,
  input wire logic        eeRdValid,
  // USB core side.
  input wire logic        usbBusReset,
  input wire logic        usbSuspend,
  input wire logic [3:0]  ep0MaxPacket,
  input wire logic [3:0]  ep1MaxPacket,
  // Status, reports and pad trims.
  input wire logic [15:0] reportBits,
  input wire logic        cfgReady,
  input wire logic        pollWake,
  input wire logic        remoteWakeReq,
  input wire logic        ledPinOut,
  input wire logic        ledPinOe,
  input wire logic [3:0]  rollerSinkCode,
  input wire logic [3:0]  ledSinkCode
);
  // A single clock domain, so one default clock and reset serve every property except p_loadDone, which also disables on a bus reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // The last configuration byte arriving from the EEPROM.
  sequence s_lastByte;
    eeRdValid && eeRdAddr == 8'h04;
  endsequence
  // A fresh load begins with reporting dropped.
  sequence s_reloadStart;
    !cfgReady && eeRdReq && eeRdAddr == 8'h00;
  endsequence
  // A bus reset restarts the load, so it suspends the completion check.
  property p_loadDone;
    @(posedge clk_sys) disable iff (rst || usbBusReset) s_lastByte |=> cfgReady;
  endproperty

  a_ep_size: assert property (ep0MaxPacket == 4'h8 && ep1MaxPacket == 4'h8)
    else $error("endpoint packet size is not eight");
  a_bus_reload: assert property (usbBusReset ##1 !usbBusReset |-> !cfgReady && !eeRdReq ##1 s_reloadStart)
    else $error("bus reset did not restart the load");
  a_load_done: assert property (p_loadDone)
    else $error("ready missing after the fifth byte");
  a_ready_cause: assert property ($rose(cfgReady) |-> $past(eeRdValid) && $past(eeRdAddr) == 8'h04)
    else $error("ready rose without the fifth byte");
  a_report_idle: assert property (!cfgReady && !$past(cfgReady) |-> reportBits == 16'h0000)
    else $error("report active before configuration");
  a_addr_range: assert property (eeRdReq |-> eeRdAddr <= 8'h04)
    else $error("read outside the configuration bytes");
  a_req_single: assert property (eeRdReq && !usbBusReset |=> !eeRdReq)
    else $error("read request longer than one cycle");
  a_sink_clamp: assert property (rollerSinkCode <= 4'h9 && ledSinkCode <= 4'h8)
    else $error("sink code above its ceiling");
  a_wake_cause: assert property (remoteWakeReq |-> pollWake)
    else $error("remote wakeup outside a poll");
  a_poll_suspend: assert property (pollWake |-> $past(usbSuspend) && $past(cfgReady) ##1 !pollWake)
    else $error("poll pulse outside suspend or too long");
  a_led_suspend: assert property (ledPinOe |-> $past(usbSuspend) && !ledPinOut)
    else $error("lamp pin driven outside suspend");
endmodule

bind hid_input_config_loader hicl_checker #(.STEP_CYCLES(STEP_CYCLES)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .eeRdReq(eeRdReq), .eeRdAddr(eeRdAddr), .eeRdValid(eeRdValid),
  .usbBusReset(usbBusReset), .usbSuspend(usbSuspend), .ep0MaxPacket(ep0MaxPacket), .ep1MaxPacket(ep1MaxPacket),
  .reportBits(reportBits), .cfgReady(cfgReady), .pollWake(pollWake), .remoteWakeReq(remoteWakeReq),
  .ledPinOut(ledPinOut), .ledPinOe(ledPinOe), .rollerSinkCode(rollerSinkCode), .ledSinkCode(ledSinkCode));
`default_nettype wire

// ---- hicl_eeprom_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// On-chip EEPROM seen from the loader: five configuration bytes and a serial echo.
module hicl_eeprom_model (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Read port.
  input  wire logic       eeRdReq,
  input  wire logic [7:0] eeRdAddr,
  input  wire logic       slow,
  output logic [7:0]      eeRdData,
  output logic            eeRdValid,
  // Serial port of the programming mode.
  input  wire logic       eeSerCs,
  input  wire logic       eeSerDi,
  output logic            eeSerDo
);
  logic [7:0] mem [0:4];  // Configuration bytes, written by the bench.
  logic [7:0] addr;       // Address of the request in flight.
  logic [1:0] cnt;        // Cycles left before the answer.

  // Answers one request after one or three cycles; between answers the data bus toggles,
  // so a loader that samples without valid picks up garbage instead of a lucky match.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr      <= 8'h00;
      cnt       <= 2'h0;
      eeRdValid <= 1'b0;
      eeRdData  <= 8'h00;
    end else begin
      eeRdValid <= 1'b0;
      eeRdData  <= ~eeRdData;
      if (eeRdReq) begin
        addr <= eeRdAddr;
        cnt  <= slow ? 2'h3 : 2'h1;
      end else if (cnt == 2'h1) begin
        cnt       <= 2'h0;
        eeRdValid <= 1'b1;
        eeRdData  <= (addr <= 8'h04) ? mem[addr[2:0]] : 8'h00;
      end else if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end
    end
  end

  // Selected part echoes its data input; deselected output idles high.
  assign eeSerDo = eeSerCs ? eeSerDi : 1'b1;
endmodule
`default_nettype wire

// ---- hid_input_config_loader_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module hid_input_config_loader_tb_top;
  localparam int unsigned STEP = 20;  // Short step keeps debounce and poll runs brief.
  logic clk_sys, rst, eeRdReq, eeRdValid, eeSerCs, eeSerSk, eeSerDi, eeSerDo, usbBusReset, usbSuspend;
  logic setReportStrobe, cfgReady, cfgError, pollWake, remoteWakeReq, ledPinOut, ledPinOe, slow;
  logic [7:0] eeRdAddr, eeRdData;
  logic [1:0] setReportData, progPinOut, progPinOe;
  logic [3:0] ep0MaxPacket, ep1MaxPacket, rollerSinkCode, ledSinkCode;
  logic [15:0] reportBits;
  hicl_pkg::hicl_pins_t pins;
  int fail_count = 0, num_checks = 0, cycles = 0;

  hid_input_config_loader #(.STEP_CYCLES(STEP)) i_dut (.clk_sys(clk_sys), .rst(rst), .pinsIn(pins),
    .eeRdReq(eeRdReq), .eeRdAddr(eeRdAddr), .eeRdData(eeRdData), .eeRdValid(eeRdValid), .eeSerCs(eeSerCs),
    .eeSerSk(eeSerSk), .eeSerDi(eeSerDi), .eeSerDo(eeSerDo), .usbBusReset(usbBusReset), .usbSuspend(usbSuspend),
    .setReportStrobe(setReportStrobe), .setReportData(setReportData), .ep0MaxPacket(ep0MaxPacket),
    .ep1MaxPacket(ep1MaxPacket), .reportBits(reportBits), .cfgReady(cfgReady), .cfgError(cfgError),
    .pollWake(pollWake), .remoteWakeReq(remoteWakeReq), .progPinOut(progPinOut), .progPinOe(progPinOe),
    .ledPinOut(ledPinOut), .ledPinOe(ledPinOe), .rollerSinkCode(rollerSinkCode), .ledSinkCode(ledSinkCode));
  hicl_eeprom_model i_ee (.clk_sys(clk_sys), .rst(rst), .eeRdReq(eeRdReq), .eeRdAddr(eeRdAddr), .slow(slow),
    .eeRdData(eeRdData), .eeRdValid(eeRdValid), .eeSerCs(eeSerCs), .eeSerDi(eeSerDi), .eeSerDo(eeSerDo));

  // Free-running 200 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // A hang is cut short well above the few thousand cycles the tests need.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Stores five bytes (byte 0 lowest), pulses bus reset and waits for the reload.
  task automatic load(input logic [39:0] c);
    int n;
    for (int i = 0; i < 5; i++) i_ee.mem[i] = c[i*8 +: 8];
    @(negedge clk_sys) usbBusReset = 1'b1;
    @(negedge clk_sys) usbBusReset = 1'b0;
    n = 0;
    while (cfgReady !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    idle(1); // The error flag trails ready by one cycle.
    check(16'(cfgReady), 16'h0001);
  endtask

  // Waits for the next poll pulse and returns the cycles spent.
  task automatic waitPoll(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pollWake !== 1'b1 && n < 200);
  endtask

  task automatic t_trims();
    slow = 1'b1;
    load({8'h08, 8'h30, 8'h00, 8'h00, 8'h5c});
    check({8'(rollerSinkCode), 8'(ledSinkCode)}, 16'h0503);
    check({8'(ep0MaxPacket), 8'(ep1MaxPacket)}, 16'h0808);
    check(16'(cfgError), 16'h0000);
    slow = 1'b0;
    load({8'h08, 8'hf0, 8'h00, 8'h00, 8'hfc});
    check({8'(rollerSinkCode), 8'(ledSinkCode)}, 16'h0908);
    $display("test trims done");
  endtask

  // Each entry breaks exactly one field of an otherwise valid set.
  task automatic t_errors();
    logic [39:0] bad [5];
    bad = '{40'h0800000008, 40'h080000050c, 40'h080100000c, 40'h0f0000000c, 40'h180000000c};
    foreach (bad[i]) begin
      load(bad[i]);
      check(16'(cfgError), 16'h0001);
    end
    load(40'h080000000c);
    check(16'(cfgError), 16'h0000);
    $display("test errors done");
  endtask

  // Pressed: B1, B5, H5, H1 and the first programmable pin; roller count changes what reaches the report.
  task automatic t_buttons();
    logic [7:0] cfg0 [5];
    logic [7:0] app [5];
    logic [15:0] exp [5];
    cfg0 = '{8'h0c, 8'h0d, 8'h0f, 8'h0f, 8'h0f};
    app = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h03};
    exp = '{16'h5101, 16'h4101, 16'h4001, 16'h4101, 16'h5101};
    pins.buttonPinN = 8'hee;
    pins.rollerPinN = 6'h2e;
    pins.progPinN = 2'b10;
    foreach (cfg0[i]) begin
      load({8'h08, app[i], 8'hff, 8'h0f, cfg0[i]});
      idle(100);
      check(reportBits, exp[i]);
    end
    pins = '1;
    $display("test buttons done");
  endtask

  task automatic t_debounce();
    load({8'h08, 8'h0c, 8'h00, 8'h01, 8'h0c});
    idle(200);
    pins.buttonPinN = 8'hfe;
    idle(50);
    check(reportBits, 16'h0000);
    idle(150);
    check(reportBits, 16'h0001);
    pins = '1;
    idle(200);
    $display("test debounce done");
  endtask

  // Strobe taken at one edge, drive enable follows one cycle later; a zero pulls the pin low.
  task automatic t_prog_out();
    logic [1:0] d [3];
    logic [1:0] oe [3];
    d = '{2'b10, 2'b01, 2'b00};
    oe = '{2'b01, 2'b10, 2'b01};
    for (int i = 0; i < 3; i++) begin
      if (i == 0) load(40'h0800000000);
      if (i == 2) load(40'h0800000004);
      @(negedge clk_sys);
      setReportStrobe = 1'b1;
      setReportData = d[i];
      @(negedge clk_sys) setReportStrobe = 1'b0;
      idle(2);
      check(16'(progPinOe), 16'(oe[i]));
    end
    $display("test prog out done");
  endtask

  task automatic t_suspend();
    int n;
    load({8'h09, 8'h00, 8'h00, 8'h7f, 8'h0d});
    usbSuspend = 1'b1;
    waitPoll(n);
    waitPoll(n);
    check(16'(n), 16'h0028);
    check(16'(ledPinOe), 16'h0001);
    pins.rollerPinN = 6'h2f;
    waitPoll(n);
    check(16'(remoteWakeReq), 16'h0001);
    waitPoll(n);
    check(16'(remoteWakeReq), 16'h0000);
    usbSuspend = 1'b0;
    load({8'h01, 8'h00, 8'h00, 8'h7f, 8'h0d});
    usbSuspend = 1'b1;
    waitPoll(n);
    check(16'(pollWake), 16'h0000);
    usbSuspend = 1'b0;
    pins = '1;
    $display("test suspend done");
  endtask

  // B1 low selects the part, B3 low sets the data bit; the echo returns on the first pin.
  task automatic t_prog_mode();
    pins.progModeN = 1'b0;
    pins.buttonPinN = 8'hfa;
    idle(6);
    check({13'h0000, eeSerCs, eeSerSk, eeSerDi}, 16'h0005);
    check({14'h0000, progPinOut}, 16'h0001);
    check(reportBits, 16'h0000);
    pins = '1;
    idle(4);
    $display("test prog mode done");
  endtask

  initial begin
    rst = 1'b1;
    pins = '1;
    usbBusReset = 1'b0;
    usbSuspend = 1'b0;
    setReportStrobe = 1'b0;
    setReportData = 2'b00;
    slow = 1'b0;
    idle(10);
    rst = 1'b0;
    t_trims();
    t_errors();
    t_buttons();
    t_debounce();
    t_prog_out();
    t_suspend();
    t_prog_mode();
    results();
  end
endmodule
`default_nettype wire
